/* pkg/lrb_defs.vh */
// Purpose: Shared constants of the LIN response, length, flag and buffer block
// Assumes: 200 MHz aclk, AXI4-Lite register access, 8-bit registers in low lane
// Notes: Offsets are byte addresses of aligned 32-bit words
`ifndef LRB_DEFS_VH
`define LRB_DEFS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define LRB_A_CTRL 8'h00
`define LRB_A_STAT 8'h04
`define LRB_A_IEN 8'h08
`define LRB_A_ERR 8'h0C
`define LRB_A_LEN 8'h10
`define LRB_A_SEL 8'h14
`define LRB_A_DAT 8'h18
// ----------------------------------------
// Commands, field positions, reset values
// ----------------------------------------
`define LRB_CMD_ABORT 3'h0
`define LRB_CMD_TXH 3'h1
`define LRB_CMD_RXR 3'h2
`define LRB_CMD_TXR 3'h3
`define LRB_CTRL_PROTO 6
`define LRB_E_BIT 0
`define LRB_E_CSUM 1
`define LRB_E_PAR 2
`define LRB_E_SYNC 3
`define LRB_E_FRAME 4
`define LRB_E_TOUT 5
`define LRB_E_OVR 6
`define LRB_E_ABORT 7
`define LRB_S_ERRSUM 3
`define LRB_RST_BYTE 8'h00
`define LRB_MAX_LEN 4'h8
`define LRB_CS_GOOD 8'hFF
`define LRB_ID_SPECIAL 4'hF
// ----------------------------------------
// Timing and bus answers
// ----------------------------------------
// Frame limit: 100 us of 200 MHz cycles, sized to the timer width
`define LRB_FRAME_MAX_CYC 20'h04E20
`define LRB_RESP_OKAY 2'h0
`define LRB_RESP_SLVERR 2'h2
`endif

/* design/lrb_core.v */
// Purpose: LIN response lengths, flags, checksum, identifier status and buffer
// Assumes: Byte and header events come from an outside serializer, synchronous
// Notes: Registers on AXI4-Lite; one write and one read outstanding at a time
//
// Function
// - Zero length sends or takes checksum only
// - Lengths above eight clamp to eight
// - Classic protocol loads lengths from identifier code
// - Receive counts bytes in transmit length
// - Transmit counts bytes in receive length
// - Byte errors reported after whole byte
// - UART mode holds lengths zero, ignores writes
// - Header and response done flags per mode
// - Summary is OR; writing one clears all
// - Monitored bit mismatch flags and aborts response send
// - Bad received checksum sum flags error
// - Identifier parity mismatch flags error, no fix
// - Sync tolerance and dominant stop flagged
// - Frame exceeding maximum time flags timeout
// - Command while busy or lost byte overruns
// - Abort while busy recorded; errors but overrun and UART framing go idle
// - Break during response aborts with error
// - Inverted end-around-carry sum, enhanced or classic
// - Protocol bit sampled at response command entry
// - Four flags with enables drive two interrupts
// - Frame status marks identifiers sixty to sixty-three
// - Indexed buffer with optional auto increment
// - Command codes for header and response
// - Busy is hardware owned, shows activity
// - Protocol bit zero enhanced, one classic
`include "lrb_defs.vh"
module lrb_core #(
  parameter [19:0] FRAME_MAX = `LRB_FRAME_MAX_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire hdr_done,
  input wire [7:0] hdr_pid,
  input wire sync_bad,
  input wire break_seen,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_stop_bad,
  output reg tx_req,
  output reg [7:0] tx_data,
  input wire tx_done,
  input wire bit_strobe,
  input wire bit_sent,
  input wire bit_seen,
  output reg [2:0] cmd_out,
  output reg irq_ok,
  output reg irq_err
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RX = 2'h1;
  localparam [1:0] S_TX = 2'h2;
  localparam [1:0] S_UTX = 2'h3;
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] st; // Response state
  reg [2:0] cmd; // Command field
  reg proto; // Protocol select, 1 is classic
  reg [2:0] ok; // Header, tx, rx done flags
  reg [7:0] err; // Error flags
  reg [3:0] ien; // Interrupt enables
  reg [3:0] txl; // Transmit length field
  reg [3:0] rxl; // Receive length field
  reg [2:0] idx; // Buffer index
  reg inc_n; // Auto increment, active low
  reg [7:0] dbuf [0:7]; // Response data bytes
  reg [7:0] acc; // Checksum accumulator
  reg [7:0] pid; // Last protected identifier
  reg [2:0] fstat; // Frame status code
  reg bit_pend; // Bit mismatch in current byte
  reg [7:0] urx; // UART received byte
  reg unread; // UART byte not yet read
  reg fin; // Response finished pulse
  reg tmr_on; // Frame timer running
  reg [19:0] tmr; // Frame timer
  reg [7:0] wa; // Held write address
  reg [7:0] wd; // Held write data
  reg wb0; // Held low lane strobe
  reg [31:0] rd_val; // Read mux result
  reg rd_hit; // Read address mapped
  integer i;
  wire busy = (st != S_IDLE);
  wire uart = cmd[2];
  wire wr_en = ~awready & ~wready & ~bvalid;
  wire wr_lo = wr_en & wb0;
  wire rd_en = arvalid & arready;
  wire wr_ctrl = wr_lo & (wa == `LRB_A_CTRL);
  wire wr_stat = wr_lo & (wa == `LRB_A_STAT);
  wire wr_dat = wr_lo & (wa == `LRB_A_DAT);
  wire rd_dat = rd_en & (araddr == `LRB_A_DAT);
  wire tout = tmr_on & (tmr == FRAME_MAX - 20'h00001);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Add with end-around carry
  function [7:0] csum;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      csum = s[7:0] + {7'h00, s[8]};
    end
  endfunction
  // Limit a length to eight
  function [3:0] clamp;
    input [3:0] v;
    begin
      clamp = (v > `LRB_MAX_LEN) ? `LRB_MAX_LEN : v;
    end
  endfunction
  // Length from identifier data length code
  function [3:0] dlc_len;
    input [1:0] c;
    begin
      case (c)
        2'h2: dlc_len = 4'h4;
        2'h3: dlc_len = 4'h8;
        default: dlc_len = 4'h2;
      endcase
    end
  endfunction
  // Expected parity bits of an identifier
  function [1:0] id_par;
    input [5:0] d;
    begin
      id_par = {~(d[1] ^ d[3] ^ d[4] ^ d[5]), d[0] ^ d[1] ^ d[2] ^ d[4]};
    end
  endfunction
  // ----------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------
  // Address and data taken in any order, answer follows both
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `LRB_RESP_OKAY;
      wa <= `LRB_RST_BYTE;
      wd <= `LRB_RST_BYTE;
      wb0 <= 1'b0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `LRB_RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      if (awvalid && awready) begin
        wa <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd <= wdata[7:0];
        wb0 <= wstrb[0];
        wready <= 1'b0;
      end
      // Both halves held: commit and answer
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= (wa > `LRB_A_DAT || wa[1:0] != 2'h0) ? `LRB_RESP_SLVERR : `LRB_RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      // Read answered on the cycle after the address
      if (rd_en) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_hit ? `LRB_RESP_OKAY : `LRB_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
  // Read data mux
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (araddr)
      `LRB_A_CTRL: rd_val = {25'h0, proto, 3'h0, cmd};
      `LRB_A_STAT: rd_val = {24'h0, fstat, busy, |err, ok};
      `LRB_A_IEN: rd_val = {28'h0, ien};
      `LRB_A_ERR: rd_val = {24'h0, err};
      `LRB_A_LEN: rd_val = {24'h0, txl, rxl};
      `LRB_A_SEL: rd_val = {28'h0, inc_n, idx};
      `LRB_A_DAT: rd_val = {24'h0, uart ? urx : dbuf[idx]};
      default: rd_hit = 1'b0;
    endcase
  end
  // ----------------------------------------
  // Frame timer
  // ----------------------------------------
  // Runs from header end until response end or any error
  always @(posedge aclk) begin
    if (!aresetn) begin
      tmr_on <= 1'b0;
      tmr <= 20'h00000;
    end else if (hdr_done && !uart) begin
      tmr_on <= 1'b1;
      tmr <= 20'h00000;
    end else if (fin || (|err) || tout) begin
      tmr_on <= 1'b0;
    end else if (tmr_on) begin
      tmr <= tmr + 20'h00001;
    end
  end
  // ----------------------------------------
  // Response engine, flags and registers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      st <= S_IDLE;
      cmd <= `LRB_CMD_ABORT;
      proto <= 1'b0;
      ok <= 3'h0;
      err <= `LRB_RST_BYTE;
      ien <= 4'h0;
      txl <= 4'h0;
      rxl <= 4'h0;
      idx <= 3'h0;
      inc_n <= 1'b0;
      acc <= `LRB_RST_BYTE;
      pid <= `LRB_RST_BYTE;
      fstat <= 3'h0;
      bit_pend <= 1'b0;
      urx <= `LRB_RST_BYTE;
      unread <= 1'b0;
      fin <= 1'b0;
      tx_req <= 1'b0;
      tx_data <= `LRB_RST_BYTE;
      cmd_out <= `LRB_CMD_ABORT;
      irq_ok <= 1'b0;
      irq_err <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        dbuf[i] <= `LRB_RST_BYTE;
      end
    end else begin
      fin <= 1'b0;
      // Software clears first; hardware sets below win
      if (wr_stat) begin
        ok <= ok & ~wd[2:0];
        if (wd[`LRB_S_ERRSUM]) begin
          err <= `LRB_RST_BYTE;
        end
      end
      if (wr_lo && wa == `LRB_A_IEN) begin
        ien <= wd[3:0];
      end
      if (wr_lo && wa == `LRB_A_SEL) begin
        idx <= wd[2:0];
        inc_n <= wd[3];
      end
      // Length writes locked while busy and in UART mode
      if (wr_lo && wa == `LRB_A_LEN && !busy && !uart) begin
        txl <= wd[7:4];
        rxl <= wd[3:0];
      end
      // Buffer access through the data register
      if (wr_dat && !uart && !busy) begin
        dbuf[idx] <= wd;
      end
      if ((wr_dat && !uart && !busy) || (rd_dat && !uart)) begin
        if (!inc_n) begin
          idx <= idx + 3'h1;
        end
      end
      if (rd_dat && uart) begin
        unread <= 1'b0;
      end
      // Command entry
      if (wr_ctrl) begin
        if (busy) begin
          if (wd[2:0] == `LRB_CMD_ABORT) begin
            err[`LRB_E_ABORT] <= 1'b1;
            st <= S_IDLE;
            tx_req <= 1'b0;
            cmd <= `LRB_CMD_ABORT;
          end else begin
            err[`LRB_E_OVR] <= 1'b1;
          end
        end else begin
          cmd <= wd[2:0];
          proto <= wd[`LRB_CTRL_PROTO];
          // Start accumulator at identifier or zero
          acc <= wd[`LRB_CTRL_PROTO] ? `LRB_RST_BYTE : pid;
          bit_pend <= 1'b0;
          if (wd[2:0] == `LRB_CMD_RXR) begin
            st <= S_RX;
            txl <= 4'h0;
            rxl <= clamp(rxl);
          end
          if (wd[2:0] == `LRB_CMD_TXR) begin
            st <= S_TX;
            rxl <= 4'h0;
            txl <= clamp(txl);
          end
        end
      end
      // Header end: identifier status and classic lengths
      if (hdr_done && !uart) begin
        ok[2] <= 1'b1;
        pid <= hdr_pid;
        fstat <= (hdr_pid[5:2] == `LRB_ID_SPECIAL) ? {1'b1, hdr_pid[1:0]} : 3'h0;
        if (proto) begin
          txl <= dlc_len(hdr_pid[5:4]);
          rxl <= dlc_len(hdr_pid[5:4]);
        end
        if (id_par(hdr_pid[5:0]) != hdr_pid[7:6]) begin
          err[`LRB_E_PAR] <= 1'b1;
        end
      end
      if (sync_bad && !uart) begin
        err[`LRB_E_SYNC] <= 1'b1;
      end
      // Monitored bit differs from sent bit
      if (bit_strobe && tx_req && (bit_sent != bit_seen)) begin
        bit_pend <= 1'b1;
      end
      case (st)
        S_RX: begin
          if (rx_valid) begin
            if (rx_stop_bad) begin
              err[`LRB_E_FRAME] <= 1'b1;
              st <= S_IDLE;
            end else if (txl < rxl) begin
              dbuf[txl[2:0]] <= rx_data;
              acc <= csum(acc, rx_data);
              txl <= txl + 4'h1;
            end else begin
              // Checksum byte; zero length lands here first
              st <= S_IDLE;
              fin <= 1'b1;
              if (csum(acc, rx_data) != `LRB_CS_GOOD) begin
                err[`LRB_E_CSUM] <= 1'b1;
              end else begin
                ok[0] <= 1'b1;
              end
            end
          end
        end
        S_TX: begin
          if (!tx_req) begin
            // Load next data byte or inverted checksum
            tx_req <= 1'b1;
            tx_data <= (rxl < txl) ? dbuf[rxl[2:0]] : ~acc;
          end else if (tx_done) begin
            tx_req <= 1'b0;
            bit_pend <= 1'b0;
            if (bit_pend) begin
              err[`LRB_E_BIT] <= 1'b1;
              st <= S_IDLE;
            end else if (rxl < txl) begin
              acc <= csum(acc, tx_data);
              rxl <= rxl + 4'h1;
            end else begin
              ok[1] <= 1'b1;
              st <= S_IDLE;
              fin <= 1'b1;
            end
          end
        end
        S_UTX: begin
          if (tx_done) begin
            tx_req <= 1'b0;
            ok[1] <= 1'b1;
            st <= S_IDLE;
          end
        end
        default: begin
          // UART send starts on a data write
          if (uart && cmd[0] && wr_dat) begin
            tx_data <= wd;
            tx_req <= 1'b1;
            st <= S_UTX;
          end
        end
      endcase
      // UART character reception
      if (uart && cmd[1] && rx_valid) begin
        if (rx_stop_bad) begin
          err[`LRB_E_FRAME] <= 1'b1;
        end else begin
          if (unread) begin
            err[`LRB_E_OVR] <= 1'b1;
          end
          urx <= rx_data;
          unread <= 1'b1;
          ok[0] <= 1'b1;
        end
      end
      // Break inside a response aborts with an error
      if (break_seen && (st == S_RX || st == S_TX)) begin
        if (st == S_TX) begin
          err[`LRB_E_BIT] <= 1'b1;
        end else begin
          err[`LRB_E_FRAME] <= 1'b1;
        end
        st <= S_IDLE;
        tx_req <= 1'b0;
      end
      if (tout) begin
        err[`LRB_E_TOUT] <= 1'b1;
      end
      // Errors other than overrun and UART framing stop activity and return to command zero
      if ((hdr_done && !uart && id_par(hdr_pid[5:0]) != hdr_pid[7:6]) || tout ||
          (sync_bad && !uart) || (break_seen && busy && !uart) ||
          (st == S_RX && rx_valid && (rx_stop_bad || (txl >= rxl &&
          csum(acc, rx_data) != `LRB_CS_GOOD))) ||
          (st == S_TX && tx_req && tx_done && bit_pend)) begin
        cmd <= `LRB_CMD_ABORT;
        st <= S_IDLE;
        tx_req <= 1'b0;
      end
      if (uart) begin
        txl <= 4'h0;
        rxl <= 4'h0;
      end
      cmd_out <= cmd;
      irq_ok <= |(ok & ien[2:0]);
      irq_err <= (|err) & ien[3];
    end
  end
endmodule // lrb_core

/* dv/lrb_core_props.sv */
// Purpose: Port checker for the LIN response core
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every core instance
module lrb_core_props (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  input wire tx_req,
  input wire [7:0] tx_data,
  input wire tx_done,
  input wire break_seen,
  input wire [2:0] cmd_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  chk_resp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_data_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  chk_byte_stands: assert property (tx_req && !tx_done |=> !tx_req || $stable(tx_data))
    else $error("send byte changed");
  chk_byte_gap: assert property (tx_req && tx_done |=> !tx_req)
    else $error("no gap after byte");
  chk_break_idle: assert property (break_seen && tx_req && cmd_out == 3'h3 |-> ##[1:3] cmd_out == 3'h0)
    else $error("break left command");
  chk_send_cmd: assert property ($rose(tx_req) |-> cmd_out == 3'h3 || cmd_out[2])
    else $error("send without command");
endmodule // lrb_core_props

bind lrb_core lrb_core_props i_lrb_core_props (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .tx_req,
  .tx_data, .tx_done, .break_seen, .cmd_out);

/* dv/lrb_far_node.sv */
// Purpose: Far LIN node that serializes, echoes and sends bytes
// Assumes: Ten-bit characters, start bit first
// Notes: Idle data lines except bit_sent carry the inverse of their last value
module lrb_far_node (
  input wire aclk,
  input wire tx_req,
  input wire [7:0] tx_data,
  output logic tx_done,
  output logic bit_strobe,
  output logic bit_sent,
  output logic bit_seen,
  output logic hdr_done,
  output logic [7:0] hdr_pid,
  output logic sync_bad,
  output logic break_seen,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_stop_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic corrupt = 1'b0; // Flip one echo
  logic [9:0] chr; // Character on the wire
  initial begin
    {tx_done, bit_strobe, bit_sent, bit_seen, hdr_done, sync_bad} = 6'h0;
    {break_seen, rx_valid, rx_stop_bad, hdr_pid, rx_data} = 19'h0;
  end
  // Serialize each request, slow or prompt
  initial forever begin
    @(posedge aclk);
    if (tx_req === 1'b1) begin
      chr = {1'b1, tx_data, 1'b0};
      repeat ($urandom_range(6, 1)) @(posedge aclk);
      for (int i = 0; i < 10 && tx_req; i++) begin
        bit_strobe <= 1'b1;
        bit_sent <= chr[i];
        bit_seen <= (corrupt && i == 4) ? ~chr[i] : chr[i];
        @(posedge aclk);
        bit_strobe <= 1'b0;
        bit_seen <= ~chr[i];
        @(posedge aclk);
      end
      corrupt <= 1'b0;
      tx_done <= tx_req;
      @(posedge aclk);
      tx_done <= 1'b0;
    end
  end
  // Header end with its identifier
  task automatic hdr(input logic [7:0] pid, input logic sbad);
    @(posedge aclk);
    hdr_done <= 1'b1;
    hdr_pid <= pid;
    sync_bad <= sbad;
    @(posedge aclk);
    hdr_done <= 1'b0;
    hdr_pid <= ~pid;
    sync_bad <= 1'b0;
  endtask
  // One received byte after a random gap
  task automatic send(input logic [7:0] d, input logic sbad);
    repeat ($urandom_range(6, 1)) @(posedge aclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_stop_bad <= sbad;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_stop_bad <= 1'b0;
  endtask
  task automatic brk();
    @(posedge aclk);
    break_seen <= 1'b1;
    @(posedge aclk);
    break_seen <= 1'b0;
  endtask
endmodule // lrb_far_node

/* dv/test_lrb_core.sv */
// Purpose: Self-checking bench of the LIN response core
// Assumes: Bench is the register bus master
// Notes: Frame limit shortened to 600 cycles
`include "lrb_defs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); fail_count++; end end
module test_lrb_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, v, pid;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  wire awready, wready, bvalid, arready, rvalid, tx_req, tx_done, hdr_done, sync_bad;
  wire break_seen, rx_valid, rx_stop_bad, bit_strobe, bit_sent, bit_seen, irq_ok, irq_err;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] tx_data, hdr_pid, rx_data;
  wire [2:0] cmd_out;
  int fail_count = 0, samples_checked = 0, cyc = 0, n, id, k;
  int tp[9] = '{0, 0, 1, 0, 0, 0, 0, 1, 0}; // Classic when set
  int tl[9] = '{10, 0, 0, 8, 8, 0, 5, 0, 3}; // Programmed length
  int tm[9] = '{0, 0, 0, 1, 2, 0, 0, 1, 2}; // Fault kind
  logic [7:0] dq[8]; // Reference buffer
  logic [7:0] sent_q[$]; // Bytes sent
  lrb_core #(.FRAME_MAX(20'd600)) i_lrb_core (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .hdr_done, .hdr_pid, .sync_bad, .break_seen, .rx_valid,
    .rx_data, .rx_stop_bad, .tx_req, .tx_data, .tx_done, .bit_strobe, .bit_sent, .bit_seen,
    .cmd_out, .irq_ok, .irq_err);
  lrb_far_node i_lrb_far_node (.aclk, .tx_req, .tx_data, .tx_done, .bit_strobe, .bit_sent,
    .bit_seen, .hdr_done, .hdr_pid, .sync_bad, .break_seen, .rx_valid, .rx_data, .rx_stop_bad);
  initial forever #2.5 aclk = ~aclk;
  // Byte capture and hang limit
  always @(posedge aclk) begin
    cyc++;
    if (tx_done && tx_req === 1'b1) sent_q.push_back(tx_data);
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  function automatic logic [7:0] mkpid(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction
  function automatic logic [7:0] csum(input int s, input int c);
    for (int j = 0; j < c; j++) s = s + dq[j] - ((s + dq[j] > 255) ? 255 : 0);
    return ~s[7:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", (a > 8'h18) ? 2'h2 : 2'h0, bresp)
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [7:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata[7:0];
    `CHK("rresp", (a > 8'h18) ? 2'h2 : 2'h0, rresp)
    if (s != "") `CHK(s, e, v)
  endtask
  // One response with reference lengths, bytes and flags
  task automatic run(input int rx, input int p, input int len, input int m);
    logic [7:0] e;
    int c;
    id = $urandom_range(59, 0);
    pid = mkpid(id[5:0]);
    n = p ? ((id[5:4] == 3) ? 8 : (id[5] ? 4 : 2)) : ((len > 8) ? 8 : len);
    sent_q.delete();
    wr(`LRB_A_CTRL, {1'b0, p[0], 6'h00});
    wr(`LRB_A_SEL, 8'h07);
    for (int j = 0; j < 8; j++) dq[j] = $urandom;
    for (int j = 0; j < 8 && !rx; j++) wr(`LRB_A_DAT, dq[(j + 7) % 8]);
    wr(`LRB_A_LEN, rx ? len[7:0] : {len[3:0], 4'h0});
    i_lrb_far_node.hdr(pid, 1'b0);
    if (p) rchk("len13", `LRB_A_LEN, {n[3:0], n[3:0]});
    if (m == 1 && !rx) i_lrb_far_node.corrupt <= 1'b1;
    wr(`LRB_A_CTRL, {1'b0, p[0], 4'h0, rx ? 2'h2 : 2'h3});
    for (int j = 0; rx && j <= n && !(m == 2 && j > 1); j++)
      i_lrb_far_node.send(j < n ? dq[j] : csum(p ? 0 : pid, n) ^ 8'(m == 1), m == 2 && j == 1);
    while (m == 2 && !rx && sent_q.size() < 2) @(negedge aclk);
    if (m == 2 && !rx) i_lrb_far_node.brk();
    v = 8'hFF;
    for (int j = 0; j < 300 && v[4] !== 1'b0; j++) rchk("", `LRB_A_STAT, 8'h00);
    e = (m == 0) ? 8'h00 : rx ? ((m == 1) ? 8'h02 : 8'h10) : 8'h01;
    c = m == 0 ? n : rx ? (m == 1 ? n : 1) : (m == 1 ? 0 : 2);
    `CHK("stat", {2'b0, e != 0, 1'b1, !rx && !e, rx && !e}, {v[7], v[4], v[3:0]})
    `CHK("irq", {e != 0, e == 0}, {irq_err, irq_ok})
    rchk("err", `LRB_A_ERR, e);
    rchk("len", `LRB_A_LEN, rx ? {c[3:0], n[3:0]} : {n[3:0], c[3:0]});
    if (m == 0 && !rx) `CHK("count", n + 1, sent_q.size())
    for (int j = 0; m == 0 && !rx && j < n; j++) `CHK("byte", dq[j], sent_q[j])
    if (m == 0 && !rx) `CHK("csum", csum(p ? 0 : pid, n), sent_q[n])
    wr(`LRB_A_SEL, 8'h00);
    for (int j = 0; m == 0 && rx && j < n; j++) rchk("rxbyte", `LRB_A_DAT, dq[j]);
    wr(`LRB_A_STAT, 8'h0F);
    rchk("clear", `LRB_A_ERR, 8'h00);
  endtask
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hDEDC));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 8; k++) rchk("reset", 8'(k * 4), 8'h00);
    wr(8'h1C, 8'hFF);
    wr(`LRB_A_IEN, 8'h0B);
    wr(`LRB_A_CTRL, 8'h04);
    wr(`LRB_A_LEN, 8'h55);
    rchk("uart", `LRB_A_LEN, 8'h00);
    // UART character send, receive and overrun
    wr(`LRB_A_CTRL, 8'h07);
    wr(`LRB_A_DAT, 8'h3C);
    i_lrb_far_node.send(8'hA5, 1'b0);
    i_lrb_far_node.send(8'h5A, 1'b0);
    while (sent_q.size() < 1) @(negedge aclk);
    `CHK("usent", 8'h3C, sent_q[0])
    rchk("urx", `LRB_A_DAT, 8'h5A);
    rchk("uovr", `LRB_A_ERR, 8'h40);
    rchk("ustat", `LRB_A_STAT, 8'h0B);
    wr(`LRB_A_STAT, 8'h0F);
    for (k = 0; k < 9; k++) run(k > 4, tp[k], tl[k], tm[k]);
    i_lrb_far_node.hdr(mkpid(6'h05), 1'b0);
    wr(`LRB_A_LEN, 8'h80);
    wr(`LRB_A_CTRL, 8'h03);
    wr(`LRB_A_CTRL, 8'h02);
    wr(`LRB_A_CTRL, 8'h00);
    rchk("ovr", `LRB_A_ERR, 8'hC0);
    `CHK("cmd", 3'h0, cmd_out)
    wr(`LRB_A_STAT, 8'h0F);
    for (id = 58; id < 64; id++) begin
      i_lrb_far_node.hdr(mkpid(id[5:0]), 1'b0);
      rchk("", `LRB_A_STAT, 8'h00);
      `CHK("fstat", (id > 59) ? {1'b1, id[1:0]} : 3'h0, {v[7], (id > 59) ? v[6:5] : 2'h0})
    end
    repeat (620) @(posedge aclk);
    rchk("tout", `LRB_A_ERR, 8'h20);
    wr(`LRB_A_STAT, 8'h0F);
    i_lrb_far_node.hdr(mkpid(6'h11) ^ 8'h80, 1'b1);
    rchk("par", `LRB_A_ERR, 8'h0C);
    final_report();
  end
endmodule // test_lrb_core
